// ---- verilog/cfs_port.sv ----
// serial frame port of the voice-band codec: frames, control registers, rate
`timescale 1ns/1ns

module cfs_port (
    input wire logic mclk,
    input wire logic rst,
    input wire logic master_select,
    input wire logic power_down_pin_n,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic frame_sync_low_in,
    output logic frame_sync_low_out,
    output logic frame_sync_low_oe,
    input wire logic din,
    output logic dout,
    input wire logic hw_secondary_request,
    input wire logic [15:0] adc_sample,
    output logic adc_sample_taken,
    output logic [15:0] dac_word,
    output logic dac_word_valid,
    input wire logic fir_overflow,
    output logic flag_out,
    output logic phone_mode,
    output logic aux_input_en,
    output logic monitor_select,
    output logic [1:0] monitor_gain,
    output logic digital_loopback,
    output logic analog_loopback,
    output logic [1:0] input_gain,
    output logic [1:0] output_gain,
    output logic [5:0] fsd_delay,
    output logic [1:0] slave_count,
    output logic powered_down
);

    // ********************************************************
    // state and local signals
    // ********************************************************
    cfs_pkg::cfs_state_t s_q;   // registered state
    cfs_pkg::cfs_state_t s_d;   // next state
    logic div_sclk;             // generated shift clock
    logic div_rise;             // generated rising edge pulse
    logic div_fall;             // generated falling edge pulse
    logic div_run;              // divider enable
    logic [3:0] rate_n;         // divisor 1 to 8
    logic [5:0] half_len;       // mclk cycles per shift clock half period
    logic pd;                   // power down request from pin or register
    logic rise;                 // shift clock rising edge in this cycle
    logic fall;                 // shift clock falling edge in this cycle
    logic start;                // a frame starts: master slot reached or host frame sync falls
    logic start_sec;            // that frame is a secondary one
    logic [15:0] tx_word;       // word loaded at frame start
    logic [15:0] rx_word;       // input word including this fall's bit
    logic [4:0] rx_addr;        // register_address_field of the input word
    logic rx_read;              // read_bit of the input word
    logic [7:0] rd_value;       // register_value_field for a read
    logic [4:0] early_addr;     // register_address_field once the upper byte is in
    logic early_read;           // read_bit once the upper byte is in

    // ********************************************************
    // sample rate and shift clock
    // ********************************************************
    // the divisor is stored as n minus one so every code is legal
    assign rate_n = {1'b0, s_q.regs.control_four[cfs_pkg::C4_RATE_MSB:cfs_pkg::C4_RATE_LSB]}
                    + cfs_pkg::RATE_ONE;

    // half period of n cycles with the pll, four times longer when bypassed,
    // so the bypassed sampling period is four times the pll one
    always_comb begin
        if (s_q.regs.control_four[cfs_pkg::C4_PLL_BYPASS]) begin
            half_len = {rate_n, 2'b00};
        end else begin
            half_len = {2'b00, rate_n};
        end
    end

    // shift clock runs only while master and powered up
    assign div_run = master_select & ~s_q.powered_down;

    cfs_sclk_div u_div (
        .mclk(mclk),
        .rst(rst),
        .run(div_run),
        .half_len(half_len),
        .sclk(div_sclk),
        .rise(div_rise),
        .fall(div_fall)
    );

    // ********************************************************
    // register read decode
    // ********************************************************
    // readable registers answer with contents, the rest with zeros;
    // decoded from the upper byte alone, before the low byte arrives
    always_comb begin
        if (early_addr == cfs_pkg::ADDR_CONTROL_ONE) begin
            rd_value = s_q.regs.control_one;
        end else if (early_addr == cfs_pkg::ADDR_CONTROL_TWO) begin
            rd_value = s_q.regs.control_two;
        end else if (early_addr == cfs_pkg::ADDR_CONTROL_THREE) begin
            rd_value = s_q.regs.control_three;
        end else if (early_addr == cfs_pkg::ADDR_CONTROL_FOUR) begin
            rd_value = s_q.regs.control_four;
        end else begin
            rd_value = cfs_pkg::READ_NONE;
        end
    end

    // ********************************************************
    // serial engine
    // ********************************************************
    // one pass per mclk: edges, frame start, shifting, word completion
    always_comb begin
        s_d = s_q;
        s_d.dac_valid = 1'b0;
        s_d.adc_taken = 1'b0;
        pd = ~power_down_pin_n | s_q.regs.control_one[cfs_pkg::C1_SW_POWER_DOWN];
        s_d.powered_down = pd;
        s_d.link_oe = master_select & ~pd;
        s_d.sclk_prev = sclk_in;
        // master uses its own edges, slave detects host clock edges
        if (master_select) begin
            rise = div_rise;
            fall = div_fall;
        end else begin
            rise = sclk_in & ~s_q.sclk_prev;
            fall = ~sclk_in & s_q.sclk_prev;
        end
        // frame start: master from its period count, slave from the host sync
        if (master_select) begin
            start = (s_q.frame_cnt == cfs_pkg::PRIMARY_SLOT)
                    | ((s_q.frame_cnt == cfs_pkg::SECONDARY_SLOT) & s_q.req_pend);
            start_sec = (s_q.frame_cnt == cfs_pkg::SECONDARY_SLOT);
        end else begin
            start = ~frame_sync_low_in & s_q.fs_prev;
            start_sec = s_q.req_pend;
        end
        // primary word: 15+1 format puts the origin bit last
        if (start_sec) begin
            tx_word = {master_select, 15'h0000};
        end else if (s_q.regs.control_two[cfs_pkg::C2_ADC_WORD16]) begin
            tx_word = adc_sample;
        end else begin
            tx_word = {adc_sample[15:1], master_select};
        end
        rx_word = {s_q.in_shift[14:0], din};
        rx_addr = rx_word[cfs_pkg::SEC_ADDR_MSB:cfs_pkg::SEC_ADDR_LSB];
        rx_read = rx_word[cfs_pkg::SEC_READ_POS];
        // after eight bits the upper byte sits in the low byte of the shifter
        early_addr = rx_word[cfs_pkg::SEC_ADDR_MSB - cfs_pkg::SEC_ADDR_LSB:0];
        early_read = rx_word[cfs_pkg::SEC_READ_POS - cfs_pkg::SEC_ADDR_LSB];

        // pending software reset returns the bank to defaults
        if (s_q.sw_reset) begin
            s_d.regs.control_one = cfs_pkg::CONTROL_ONE_RST;
            s_d.regs.control_two = cfs_pkg::CONTROL_TWO_RST;
            s_d.regs.control_three = cfs_pkg::CONTROL_THREE_RST;
            s_d.regs.control_four = cfs_pkg::CONTROL_FOUR_RST;
            s_d.sw_reset = 1'b0;
        end

        if (pd) begin
            // power down: counters and link idle, registers kept
            s_d.frame_cnt = cfs_pkg::PRIMARY_SLOT;
            s_d.active = 1'b0;
            s_d.bit_cnt = 4'h0;
            s_d.req_pend = 1'b0;
            s_d.fs_out = 1'b1;
            s_d.fs_prev = 1'b1;
            s_d.dout = 1'b0;
        end else begin
            // rising edge: advance period, shift out, open or close interval
            if (rise) begin
                s_d.fs_prev = frame_sync_low_in;
                if (master_select) begin
                    s_d.frame_cnt = s_q.frame_cnt + cfs_pkg::FRAME_STEP;
                end
                if (s_q.active) begin
                    if (s_q.bit_cnt == cfs_pkg::LAST_BIT) begin
                        // seventeenth rising edge ends the interval
                        s_d.active = 1'b0;
                        s_d.fs_out = 1'b1;
                        s_d.dout = 1'b0;
                    end else begin
                        // next bit, stable for the following falling edge
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        s_d.dout = s_q.out_word[15];
                        s_d.out_word = {s_q.out_word[14:0], 1'b0};
                    end
                end else if (start) begin
                    // frame sync falls: first bit goes out now
                    s_d.active = 1'b1;
                    s_d.secondary = start_sec;
                    s_d.bit_cnt = 4'h0;
                    s_d.fs_out = 1'b0;
                    s_d.dout = tx_word[15];
                    s_d.out_word = {tx_word[14:0], 1'b0};
                    if (start_sec) begin
                        s_d.req_pend = 1'b0;
                    end else begin
                        s_d.hw_seen = 1'b0;
                        s_d.adc_taken = 1'b1;
                    end
                end
            end
            // falling edge: capture input and finish words
            if (fall && s_q.active) begin
                s_d.in_shift = rx_word;
                if (!s_q.secondary && hw_secondary_request) begin
                    s_d.hw_seen = 1'b1;
                end
                // upper byte complete: a read fills the low byte
                if (s_q.secondary && (s_q.bit_cnt == cfs_pkg::ADDR_DONE_BIT) && early_read) begin
                    s_d.out_word[15:8] = rd_value;
                end
                if (s_q.bit_cnt == cfs_pkg::LAST_BIT) begin
                    if (!s_q.secondary) begin
                        // primary word done: deliver and check requests
                        s_d.dac_word = rx_word;
                        s_d.dac_valid = 1'b1;
                        if (s_q.hw_seen || hw_secondary_request ||
                            (!s_q.regs.control_one[cfs_pkg::C1_DAC_WORD16] && rx_word[0])) begin
                            s_d.req_pend = 1'b1;
                        end
                    end else if (!rx_read) begin
                        // write only with read bit clear; zero and test
                        // addresses store nothing
                        if (rx_addr == cfs_pkg::ADDR_NOOP_PSEUDO) begin
                            s_d.sw_reset = s_q.sw_reset;
                        end else if (rx_addr == cfs_pkg::ADDR_CONTROL_ONE) begin
                            s_d.regs.control_one = rx_word[7:0];
                            s_d.sw_reset = rx_word[cfs_pkg::C1_SW_RESET];
                        end else if (rx_addr == cfs_pkg::ADDR_CONTROL_TWO) begin
                            s_d.regs.control_two = rx_word[7:0];
                        end else if (rx_addr == cfs_pkg::ADDR_CONTROL_THREE) begin
                            s_d.regs.control_three = rx_word[7:0];
                        end else if (rx_addr == cfs_pkg::ADDR_CONTROL_FOUR) begin
                            s_d.regs.control_four = rx_word[7:0];
                        end else begin
                            s_d.sw_reset = s_q.sw_reset;
                        end
                    end
                end
            end
        end

        // overflow is sticky; a new event beats a clearing write
        if (fir_overflow) begin
            s_d.regs.control_two[cfs_pkg::C2_FIR_OVERFLOW] = 1'b1;
        end
    end

    // ********************************************************
    // state register
    // ********************************************************
    // asynchronous reset to idle link and default registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.regs.control_one <= cfs_pkg::CONTROL_ONE_RST;
            s_q.regs.control_two <= cfs_pkg::CONTROL_TWO_RST;
            s_q.regs.control_three <= cfs_pkg::CONTROL_THREE_RST;
            s_q.regs.control_four <= cfs_pkg::CONTROL_FOUR_RST;
            s_q.fs_out <= 1'b1;
            s_q.fs_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ********************************************************
    // outputs, all from flip-flops
    // ********************************************************
    assign sclk_out = div_sclk;
    assign sclk_oe = s_q.link_oe;
    assign frame_sync_low_out = s_q.fs_out;
    assign frame_sync_low_oe = s_q.link_oe;
    assign dout = s_q.dout;
    assign adc_sample_taken = s_q.adc_taken;
    assign dac_word = s_q.dac_word;
    assign dac_word_valid = s_q.dac_valid;
    assign flag_out = s_q.regs.control_two[cfs_pkg::C2_FLAG_OUT];
    assign phone_mode = s_q.regs.control_two[cfs_pkg::C2_PHONE_MODE];
    assign analog_loopback = s_q.regs.control_two[cfs_pkg::C2_ANALOG_LOOPBACK];
    assign aux_input_en = s_q.regs.control_one[cfs_pkg::C1_AUX_INPUT_EN];
    assign monitor_select = s_q.regs.control_one[cfs_pkg::C1_MONITOR_SELECT];
    assign monitor_gain = s_q.regs.control_one[cfs_pkg::C1_MON_GAIN_MSB:cfs_pkg::C1_MON_GAIN_LSB];
    assign digital_loopback = s_q.regs.control_one[cfs_pkg::C1_DIGITAL_LOOPBACK];
    assign input_gain = s_q.regs.control_four[cfs_pkg::C4_IN_GAIN_MSB:cfs_pkg::C4_IN_GAIN_LSB];
    assign output_gain = s_q.regs.control_four[cfs_pkg::C4_OUT_GAIN_MSB:cfs_pkg::C4_OUT_GAIN_LSB];
    assign fsd_delay = s_q.regs.control_three[cfs_pkg::C3_FSD_DELAY_MSB:cfs_pkg::C3_FSD_DELAY_LSB];
    assign slave_count = s_q.regs.control_three[cfs_pkg::C3_SLAVES_MSB:cfs_pkg::C3_SLAVES_LSB];
    assign powered_down = s_q.powered_down;

endmodule

// ---- verilog/cfs_pkg.sv ----
// constants, register map and state types of the codec serial frame port
package cfs_pkg;

    // ********************************************************
    // serial frame geometry
    // ********************************************************
    localparam logic [4:0] WORD_BITS = 5'h10;      // bits in one data transfer interval
    localparam logic [3:0] LAST_BIT = 4'hf;        // index of the sixteenth shift clock
    localparam logic [3:0] ADDR_DONE_BIT = 4'h7;   // fall that completes the upper byte
    localparam logic [7:0] PRIMARY_SLOT = 8'h00;   // shift clock of the primary frame sync
    localparam logic [7:0] SECONDARY_SLOT = 8'h80; // shift clock of the secondary frame sync
    localparam logic [7:0] FRAME_STEP = 8'h01;     // period of 256 shift clocks by wrap

    // ********************************************************
    // shift clock divider
    // ********************************************************
    localparam logic [3:0] RATE_ONE = 4'h1;        // added to the stored divisor field
    localparam logic [5:0] HALF_STEP = 6'h01;      // divider count increment

    // ********************************************************
    // register addresses
    // ********************************************************
    localparam logic [4:0] ADDR_NOOP_PSEUDO = 5'h00;
    localparam logic [4:0] ADDR_CONTROL_ONE = 5'h01;
    localparam logic [4:0] ADDR_CONTROL_TWO = 5'h02;
    localparam logic [4:0] ADDR_CONTROL_THREE = 5'h03;
    localparam logic [4:0] ADDR_CONTROL_FOUR = 5'h04;
    localparam logic [4:0] ADDR_FACTORY_TEST_A = 5'h05;
    localparam logic [4:0] ADDR_FACTORY_TEST_B = 5'h06;

    // ********************************************************
    // reset values
    // ********************************************************
    localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
    localparam logic [7:0] CONTROL_TWO_RST = 8'h00;   // adc word format 15+1 after power-up
    localparam logic [7:0] CONTROL_THREE_RST = 8'h00;
    localparam logic [7:0] CONTROL_FOUR_RST = 8'h00;  // pll on, divisor 1
    localparam logic [7:0] READ_NONE = 8'h00;         // answer for unreadable addresses

    // ********************************************************
    // secondary word fields
    // ********************************************************
    localparam int SEC_READ_POS = 13;   // read_bit
    localparam int SEC_ADDR_MSB = 12;   // register_address_field top
    localparam int SEC_ADDR_LSB = 8;    // register_address_field bottom

    // ********************************************************
    // field positions in control registers
    // ********************************************************
    localparam int C1_SW_RESET = 7;
    localparam int C1_SW_POWER_DOWN = 6;
    localparam int C1_AUX_INPUT_EN = 5;
    localparam int C1_MONITOR_SELECT = 4;
    localparam int C1_MON_GAIN_MSB = 3;
    localparam int C1_MON_GAIN_LSB = 2;
    localparam int C1_DIGITAL_LOOPBACK = 1;
    localparam int C1_DAC_WORD16 = 0;
    localparam int C2_ANALOG_LOOPBACK = 5;
    localparam int C2_ADC_WORD16 = 4;
    localparam int C2_FIR_OVERFLOW = 3;
    localparam int C2_PHONE_MODE = 1;
    localparam int C2_FLAG_OUT = 0;
    localparam int C3_SLAVES_MSB = 7;
    localparam int C3_SLAVES_LSB = 6;
    localparam int C3_FSD_DELAY_MSB = 5;
    localparam int C3_FSD_DELAY_LSB = 0;
    localparam int C4_PLL_BYPASS = 7;       // pll_bypass_bit
    localparam int C4_RATE_MSB = 6;
    localparam int C4_RATE_LSB = 4;
    localparam int C4_IN_GAIN_MSB = 3;
    localparam int C4_IN_GAIN_LSB = 2;
    localparam int C4_OUT_GAIN_MSB = 1;
    localparam int C4_OUT_GAIN_LSB = 0;

    // control register bank
    typedef struct packed {
        logic [7:0] control_one;
        logic [7:0] control_two;
        logic [7:0] control_three;
        logic [7:0] control_four;
    } cfs_regs_t;

    // whole state of the serial engine
    typedef struct packed {
        cfs_regs_t regs;          // control registers
        logic [7:0] frame_cnt;    // shift clocks into the sampling period
        logic active;             // inside a data transfer interval
        logic secondary;          // current interval is a control exchange
        logic [3:0] bit_cnt;      // shift clock index inside the interval
        logic [15:0] in_shift;    // serial input assembly
        logic [15:0] out_word;    // serial output shifter
        logic req_pend;           // secondary exchange requested
        logic hw_seen;            // hardware request seen in this primary interval
        logic dout;               // serial data out
        logic fs_out;             // frame sync driven in master mode
        logic link_oe;            // drive enable of shift clock and frame sync
        logic fs_prev;            // frame sync level at previous rising edge
        logic sclk_prev;          // shift clock level in previous cycle (slave)
        logic [15:0] dac_word;    // last converter word received
        logic dac_valid;          // one cycle pulse with a new dac word
        logic adc_taken;          // one cycle pulse when adc sample is loaded
        logic sw_reset;           // pending software reset of the registers
        logic powered_down;       // serial interface disabled
    } cfs_state_t;

    // divider state
    typedef struct packed {
        logic [5:0] cnt;          // mclk cycles in current half period
        logic sclk;               // generated shift clock
        logic rise;               // pulse with the rising edge
        logic fall;               // pulse with the falling edge
    } cfs_div_t;

endpackage

// ---- verilog/cfs_sclk_div.sv ----
// shift clock generator of the master end
`timescale 1ns/1ns
module cfs_sclk_div (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [5:0] half_len,
    output logic sclk,
    output logic rise,
    output logic fall
);

    // ********************************************************
    // divider state
    // ********************************************************
    cfs_pkg::cfs_div_t s_q;   // registered state
    cfs_pkg::cfs_div_t s_d;   // next state

    // toggle the clock every half_len cycles, held low while stopped
    always_comb begin
        s_d = s_q;
        s_d.rise = 1'b0;
        s_d.fall = 1'b0;
        if (!run) begin
            // stopped: clock parks low, count restarts
            s_d.cnt = 6'h00;
            s_d.sclk = 1'b0;
        end else if (s_q.cnt + cfs_pkg::HALF_STEP >= half_len) begin
            // end of half period: flip and flag the edge
            s_d.cnt = 6'h00;
            s_d.sclk = ~s_q.sclk;
            s_d.rise = ~s_q.sclk;
            s_d.fall = s_q.sclk;
        end else begin
            s_d.cnt = s_q.cnt + cfs_pkg::HALF_STEP;
        end
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sclk = s_q.sclk;
    assign rise = s_q.rise;
    assign fall = s_q.fall;

endmodule

// ---- testbench/cfs_port_properties.sv ----
// timing checks on the serial frame port
`timescale 1ns/1ns
module cfs_port_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic frame_sync_low_out,
    input wire logic frame_sync_low_oe,
    input wire logic dout,
    input wire logic adc_sample_taken,
    input wire logic dac_word_valid,
    input wire logic flag_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_frame_len: assert property ($fell(frame_sync_low_out) |->
        ##31 !frame_sync_low_out ##1 frame_sync_low_out) else $error("interval length off");
    a_sample_period: assert property (adc_sample_taken |->
        ##[512:512] adc_sample_taken) else $error("sampling period off");
    a_take_fs: assert property (adc_sample_taken |-> $fell(frame_sync_low_out))
        else $error("sample taken outside primary start");
    a_dout_idle: assert property (frame_sync_low_out && $past(frame_sync_low_out) |->
        !dout) else $error("dout driven outside interval");
    a_dac_end: assert property (dac_word_valid |-> ##[0:2] $rose(frame_sync_low_out))
        else $error("dac word not at interval end");
    a_sclk_quiet: assert property (!sclk_oe |-> !sclk_out) else $error("clock while off");
    a_oe_pair: assert property (sclk_oe == frame_sync_low_oe) else $error("enables split");
    a_ctl_update: assert property ($changed(flag_out) |->
        ##[0:2] $rose(frame_sync_low_out)) else $error("flag moved mid interval");
endmodule
bind cfs_port cfs_port_checker chk_u (.mclk(mclk), .rst(rst), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .frame_sync_low_out(frame_sync_low_out), .dout(dout),
    .frame_sync_low_oe(frame_sync_low_oe), .adc_sample_taken(adc_sample_taken),
    .dac_word_valid(dac_word_valid), .flag_out(flag_out));

// ---- testbench/cfs_host_model.sv ----
// host serial port model: feeds din msb first, collects dout on falls
`timescale 1ns/1ns
module cfs_host_model (
    input wire logic mclk,
    input wire logic sclk,
    input wire logic frame_sync_low,
    input wire logic dout,
    input wire logic [15:0] tx_word,
    output logic din,
    output logic [15:0] rx_word
);
    // host keeps the pll on: the rate stays far above seven kilohertz
    logic sclk_q = 1'b0; // shift clock one cycle ago
    logic fall_q = 1'b0; // fall seen, acted on one cycle later
    logic [3:0] idx = 4'h0; // bit index inside the interval
    logic last = 1'b0; // last bit driven
    // framed: current bit; idle: inverse of the last bit, no pull on the line
    assign din = !frame_sync_low ? tx_word[4'hf - idx] : !last;
    // latch dout and move to the next bit on each shift clock fall
    always @(posedge mclk) begin
        sclk_q <= sclk;
        fall_q <= sclk_q && !sclk;
        if (frame_sync_low) idx <= 4'h0;
        else if (fall_q) begin
            idx <= idx + 4'h1;
            last <= din;
            rx_word <= {rx_word[14:0], dout};
        end
    end
endmodule

// ---- testbench/cfs_port_tb_top.sv ----
// testbench of the serial frame port in master mode
`timescale 1ns/1ns
module cfs_port_tb_top;
    logic mclk = 1'b0, rst = 1'b1, hw_req = 1'b0, sclk, fs, din, dout, take, flag, phone, aloop;
    logic [15:0] adc = 16'h1234, tx = 16'h0000, rx, dword;
    int num_errors = 0, cmp_count = 0;
    always #10 mclk = ~mclk;
    cfs_port dut_u (.mclk(mclk), .rst(rst), .master_select(1'b1), .power_down_pin_n(1'b1),
        .sclk_in(1'b0), .sclk_out(sclk), .sclk_oe(), .frame_sync_low_in(1'b1), .din(din),
        .frame_sync_low_out(fs), .frame_sync_low_oe(), .dout(dout), .adc_sample(adc),
        .hw_secondary_request(hw_req), .adc_sample_taken(take), .dac_word(dword),
        .dac_word_valid(), .fir_overflow(1'b0), .flag_out(flag), .phone_mode(phone),
        .aux_input_en(), .monitor_select(), .monitor_gain(), .digital_loopback(),
        .analog_loopback(aloop), .input_gain(), .output_gain(), .fsd_delay(),
        .slave_count(), .powered_down());
    cfs_host_model host_u (.mclk(mclk), .sclk(sclk), .frame_sync_low(fs), .dout(dout),
        .tx_word(tx), .din(din), .rx_word(rx));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // one interval with host word w: compare word out and interval kind
    task automatic fr(input logic [15:0] w, input logic [15:0] exp, input logic prim);
        tx = w;
        for (int i = 0; i < 900 && fs !== 1'b0; i++) @(posedge mclk) #2;
        check({15'h0, take}, {15'h0, prim});
        for (int i = 0; i < 60 && fs !== 1'b1; i++) @(posedge mclk) #2;
        check(rx, exp);
    endtask
    task automatic t_primary;
        fr(16'h0001, {adc[15:1], 1'b1}, 1'b1);
        check(dword, 16'h0001);
        $display("primary test done");
    endtask
    task automatic t_write;
        fr(16'h0213, 16'h8000, 1'b0);
        check({14'h0, flag, phone}, 16'h0003);
        $display("write test done");
    endtask
    task automatic t_read;
        fr(16'h0001, adc, 1'b1);
        fr(16'h22ff, 16'h8013, 1'b0);
        check({15'h0, aloop}, 16'h0000);
        $display("read test done");
    endtask
    task automatic t_noop;
        hw_req = 1'b1;
        fr(16'h0000, adc, 1'b1);
        hw_req = 1'b0;
        fr(16'h00ff, 16'h8000, 1'b0);
        check({14'h0, flag, phone}, 16'h0003);
        $display("no-op test done");
    endtask
    // test address five is only ever read, never written; address six is never accessed
    task automatic t_nosec;
        adc = 16'hbeef;
        fr(16'h0000, 16'hbeef, 1'b1);
        fr(16'h0001, 16'hbeef, 1'b1);
        fr(16'h2500, 16'h8000, 1'b0);
        $display("request test done");
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence after 12 cycles of reset
    initial begin
        repeat (12) @(posedge mclk);
        #2 rst = 1'b0;
        t_primary;
        t_write;
        t_read;
        t_noop;
        t_nosec;
        report_and_stop;
    end
    // watchdog: about eight times the time the frames should take
    initial begin
        #400000;
        num_errors++;
        report_and_stop;
    end
endmodule
